// ### src/sonet_tx_pkg.sv
package sonet_tx_pkg;

  // Frame geometry: STS-3 transport overhead, 9 rows by 270 columns
  localparam int unsigned ROWS      = 9;
  localparam int unsigned COLS      = 270;
  localparam int unsigned TOH_COLS  = 9;
  localparam int unsigned STS_N     = 3;

  localparam logic [7:0] FRAMING_1  = 8'hF6;
  localparam logic [7:0] FRAMING_2  = 8'h28;
  localparam logic [7:0] IDLE_RESET = 8'h20;
  localparam int unsigned TRACE_LEN = 16;

  // TOH byte positions as row*9+col within the three-column layout
  localparam logic [6:0] POS_J0 = 7'h06;
  localparam logic [6:0] POS_B1 = 7'h09;
  localparam logic [6:0] POS_E1 = 7'h0C;
  localparam logic [6:0] POS_F1 = 7'h0F;
  localparam logic [6:0] POS_D1 = 7'h12;
  localparam logic [6:0] POS_H1 = 7'h1B;
  localparam logic [6:0] POS_H2 = 7'h1E;
  localparam logic [6:0] POS_H3 = 7'h21;
  localparam logic [6:0] POS_B2 = 7'h24;
  localparam logic [6:0] POS_K1 = 7'h27;
  localparam logic [6:0] POS_K2 = 7'h2A;
  localparam logic [6:0] POS_S1 = 7'h48;
  localparam logic [6:0] POS_Z2 = 7'h4B;
  localparam logic [6:0] POS_M1 = 7'h4D;
  localparam logic [6:0] POS_E2 = 7'h4E;

  localparam logic [9:0] PTR_H1 = 10'h000;

  typedef enum logic [3:0] {
    PAT_USER32, PAT_USER2048, PAT_PRBS9, PAT_PRBS11, PAT_PRBS15, PAT_PRBS20,
    PAT_PRBS23, PAT_PRBS31, PAT_ZERO, PAT_ONE, PAT_ALT11, PAT_ALT13,
    PAT_ALT17, PAT_TWO_IN_8
  } pattern_t;

  typedef enum logic [2:0] {
    CONT_C4, CONT_C3_3C, CONT_C3_1, CONT_C12, CONT_C11
  } container_t;

  typedef enum logic [1:0] {
    TCM_OFF, TCM_Z5_STS3C, TCM_Z5_STS1, TCM_Z6_VT
  } tcm_t;

  typedef enum logic [1:0] {
    MUX_STS3C, MUX_STS1, MUX_VT
  } mux_t;

  typedef struct packed {
    logic [3:0] rei;
    logic       rdi;
    logic [1:0] rsvd;
    logic       spare;
  } g1_t;

  typedef struct packed {
    logic [3:0] aps;
    logic [1:0] spare;
    logic [1:0] link;
  } z4_t;

  typedef struct packed {
    logic [1:0] bip2;
    logic       rei;
    logic       rfi;
    logic [2:0] label;
    logic       rdi;
  } v5_t;

  typedef struct packed {
    logic       ext_label;
    logic       lo_vcat;
    logic [1:0] aps;
    logic [2:0] rsvd;
    logic       link;
  } z7_t;

  typedef struct packed {
    logic [7:0] j0;
    logic [7:0] e1;
    logic [7:0] f1;
    logic [7:0] dcc_sec;
    logic [7:0] k1;
    logic [4:0] k2_aps;
    logic [2:0] k2_rdi;
    logic [7:0] dcc_line;
    logic [7:0] s1;
    logic [7:0] z2;
    logic [7:0] m0;
    logic [7:0] m1;
    logic [7:0] e2;
  } toh_cfg_t;

  typedef struct packed {
    logic [7:0] j1;
    logic [7:0] c2;
    g1_t        g1;
    z4_t        z4;
    v5_t        v5;
    z7_t        z7;
  } poh_cfg_t;

endpackage

// ### src/sonet_tx_overhead_pattern_gen.sv
// How it works
// - A1 sends F6, A2 sends 28
// - B1 always computed BIP-8, never configured
// - B2 computed as one BIP-8, same byte in each B2 slot, user values refused
// - H1-H3 come only from pointer logic
// - K1, K2 bits1-5 APS; K2 bits6-8 RDI-L
// - M0/M1 carry REI-L; Z2 spare configurable
// - E1 section, E2 line; D1-3, D4-12 channels
// - Three-column layout replicated for wider rates
// - Trace messages padded with idle, default 20h
// - B3 computed BIP-8, not configurable
// - G1: REI 1-4, RDI 5, reserved, spare
// - Z4: APS 1-4, spare 5-6, link 7-8
// - V5: BIP-2, REI, RFI, label, RDI
// - Z7: label, vcat, APS, reserved, link
// - User pattern of 32 or 2048 bits
// - PRBS9 to PRBS31 with optional inversion
// - Constant all-zero and all-one patterns
// - Alternating 1:1, 1:3, 1:7 and 2-in-8
// - Preset picks inverted PRBS23 or PRBS15
// - TCM selection forces matching multiplex structure
`timescale 1ns/1ps
`default_nettype none
module sonet_tx_overhead_pattern_gen
  import sonet_tx_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  input  wire toh_cfg_t     toh_cfg_i,
  input  wire poh_cfg_t     poh_cfg_i,
  input  wire logic [1:0]   rate_sel_i,
  input  wire logic [7:0]   b2_user_i,
  input  wire logic         b2_user_we_i,
  input  wire logic [7:0]   idle_char_i,
  input  wire logic         idle_char_we_i,
  input  wire logic [7:0]   trace_char_i,
  input  wire logic [3:0]   trace_addr_i,
  input  wire logic         trace_we_i,
  input  wire pattern_t     pattern_i,
  input  wire logic         invert_i,
  input  wire logic         preset_i,
  input  wire container_t   container_i,
  input  wire tcm_t         tcm_i,
  input  wire logic [31:0]  user_word_i,
  input  wire logic [5:0]   user_addr_i,
  input  wire logic         user_we_i,
  output logic [7:0]        byte_o,
  output logic              frame_start_o,
  output logic              b2_reject_o,
  output mux_t              mux_o,
  output pattern_t          pattern_o,
  output logic              invert_o
);

  logic [3:0]   row_r;
  logic [8:0]   col_r;
  logic [1:0]   sub_r;
  logic [7:0]   b1_acc_r;
  logic [7:0]   b1_r;
  logic [7:0]   b2_acc_r;
  logic [7:0]   b2_r;
  logic [7:0]   b3_acc_r;
  logic [7:0]   b3_r;
  logic [7:0]   idle_r;
  logic [7:0]   trace_r [TRACE_LEN];
  logic [3:0]   trace_idx_r;
  logic [31:0]  user_r [64];
  logic [10:0]  ubit_r;
  logic [30:0]  lfsr_r;
  logic [7:0]   rot_r;
  pattern_t     pat_r;
  pattern_t     pat_q_r;
  logic         inv_r;
  mux_t         mux_r;
  logic         b2_rej_r;
  logic [7:0]   byte_nxt;
  logic [7:0]   pay_byte;
  logic [30:0]  lfsr_nxt;
  logic [10:0]  ubit_nxt;
  logic [6:0]   pos;
  logic         toh_col;
  logic         last_col;
  logic [2:0]   lanes;

  // Index of the last STS-3 group interleaved at the chosen rate (groups minus one)
  function automatic logic [1:0] lanes_of(input logic [1:0] sel);
    lanes_of = sel;
  endfunction

  function automatic logic [30:0] prbs_step(input pattern_t p, input logic [30:0] s);
    logic fb;
    fb = 1'b0;
    unique case (p)
      PAT_PRBS9:  fb = s[8] ^ s[4];
      PAT_PRBS11: fb = s[10] ^ s[8];
      PAT_PRBS15: fb = s[14] ^ s[13];
      PAT_PRBS20: fb = s[19] ^ s[2];
      PAT_PRBS23: fb = s[22] ^ s[17];
      PAT_PRBS31: fb = s[30] ^ s[27];
      default:    fb = 1'b0;
    endcase
    prbs_step = {s[29:0], fb};
  endfunction

  assign lanes    = {1'b0, lanes_of(rate_sel_i)};
  assign toh_col  = (col_r < 9'(TOH_COLS));
  assign last_col = (col_r == 9'(COLS - 1));
  // Columns collapse onto the three-column layout for replication
  assign pos      = 7'(row_r * 4'(TOH_COLS) + (col_r / 9'(STS_N)) * 9'(STS_N));

  // Frame counters
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      row_r <= '0;
      col_r <= '0;
      sub_r <= '0;
    end else begin
      if (sub_r >= 2'(lanes)) begin
        sub_r <= '0;
        if (last_col) begin
          col_r <= '0;
          row_r <= (row_r == 4'(ROWS - 1)) ? 4'h0 : row_r + 4'h1;
        end else begin
          col_r <= col_r + 9'h001;
        end
      end else begin
        sub_r <= sub_r + 2'h1;
      end
    end
  end

  // Configured trace and idle storage
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_r <= IDLE_RESET;
    end else if (idle_char_we_i) begin
      idle_r <= idle_char_i;
    end
  end

  // Cleared so unwritten trace bytes pad with idle, never unknown
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < TRACE_LEN; i++) begin
        trace_r[i] <= 8'h00;
      end
      for (int i = 0; i < 64; i++) begin
        user_r[i] <= 32'h0000_0000;
      end
    end else begin
      if (trace_we_i) begin
        trace_r[trace_addr_i] <= trace_char_i;
      end
      if (user_we_i) begin
        user_r[user_addr_i] <= user_word_i;
      end
    end
  end

  // Trace index steps once per frame
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trace_idx_r <= '0;
    end else if (frame_start_o) begin
      trace_idx_r <= trace_idx_r + 4'h1;
    end
  end

  // User B2 writes are refused and flagged
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      b2_rej_r <= 1'b0;
    end else begin
      b2_rej_r <= b2_user_we_i;
    end
  end

  // Parity over each frame, latched at its end for the next frame
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      b1_acc_r <= '0;
      b2_acc_r <= '0;
      b3_acc_r <= '0;
      b1_r     <= '0;
      b2_r     <= '0;
      b3_r     <= '0;
    end else if (frame_start_o) begin
      b1_r     <= b1_acc_r;
      b2_r     <= b2_acc_r;
      b3_r     <= b3_acc_r;
      b1_acc_r <= byte_nxt;
      b2_acc_r <= '0;
      b3_acc_r <= '0;
    end else begin
      b1_acc_r <= b1_acc_r ^ byte_nxt;
      if (!(toh_col && row_r < 4'h3)) begin
        b2_acc_r <= b2_acc_r ^ byte_nxt;
      end
      if (!toh_col) begin
        b3_acc_r <= b3_acc_r ^ byte_nxt;
      end
    end
  end

  // Pattern selection, preset and TCM-forced structure
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pat_r <= PAT_PRBS15;
      inv_r <= 1'b0;
    end else if (preset_i) begin
      pat_r <= (container_i == CONT_C4 || container_i == CONT_C3_3C)
               ? PAT_PRBS23 : PAT_PRBS15;
      inv_r <= 1'b1;
    end else begin
      pat_r <= pattern_i;
      inv_r <= invert_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mux_r <= MUX_STS3C;
    end else begin
      unique case (tcm_i)
        TCM_Z5_STS3C: mux_r <= MUX_STS3C;
        TCM_Z5_STS1:  mux_r <= MUX_STS1;
        TCM_Z6_VT:    mux_r <= MUX_VT;
        TCM_OFF:      mux_r <= mux_r;
      endcase
    end
  end

  // Payload pattern byte assembly
  always_comb begin
    lfsr_nxt = lfsr_r;
    ubit_nxt = ubit_r;
    pay_byte = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      unique case (pat_r)
        PAT_USER32: begin
          pay_byte[i] = user_r[0][5'(ubit_nxt)];
          ubit_nxt = (ubit_nxt[4:0] == 5'h1F) ? 11'h000 : ubit_nxt + 11'h001;
        end
        PAT_USER2048: begin
          pay_byte[i] = user_r[ubit_nxt[10:5]][ubit_nxt[4:0]];
          ubit_nxt = ubit_nxt + 11'h001;
        end
        PAT_ZERO:     pay_byte[i] = 1'b0;
        PAT_ONE:      pay_byte[i] = 1'b1;
        PAT_ALT11, PAT_ALT13, PAT_ALT17, PAT_TWO_IN_8: pay_byte[i] = 1'b0;
        default: begin
          lfsr_nxt = prbs_step(pat_r, lfsr_nxt);
          pay_byte[i] = lfsr_nxt[0];
        end
      endcase
    end
    unique case (pat_r)
      PAT_ALT11:    pay_byte = 8'h55;
      PAT_ALT13:    pay_byte = 8'h88;
      PAT_ALT17:    pay_byte = 8'h80;
      PAT_TWO_IN_8: pay_byte = 8'h42;
      default:      pay_byte = pay_byte;
    endcase
    if (inv_r) begin
      pay_byte = ~pay_byte;
    end
  end

  // Generator state restarts whenever the type changes
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lfsr_r  <= '1;
      ubit_r  <= '0;
      pat_q_r <= PAT_PRBS15;
    end else begin
      pat_q_r <= pat_r;
      if (pat_q_r != pat_r) begin
        lfsr_r <= '1;
        ubit_r <= '0;
      end else if (!toh_col) begin
        lfsr_r <= lfsr_nxt;
        ubit_r <= ubit_nxt;
      end
    end
  end

  // Outgoing byte
  always_comb begin
    byte_nxt = pay_byte;
    if (toh_col) begin
      unique case (pos)
        7'h00:  byte_nxt = FRAMING_1;
        7'h03:  byte_nxt = FRAMING_2;
        POS_J0: byte_nxt = (trace_r[trace_idx_r] == 8'h00) ? idle_r
                            : trace_r[trace_idx_r];
        POS_B1: byte_nxt = b1_r;
        POS_E1: byte_nxt = toh_cfg_i.e1;
        POS_F1: byte_nxt = toh_cfg_i.f1;
        POS_D1, 7'h15, 7'h18: byte_nxt = toh_cfg_i.dcc_sec;
        POS_H1, POS_H2: byte_nxt = PTR_H1[7:0];
        POS_H3: byte_nxt = 8'h00;
        POS_B2: byte_nxt = b2_r;
        POS_K1: byte_nxt = toh_cfg_i.k1;
        POS_K2: byte_nxt = {toh_cfg_i.k2_aps, toh_cfg_i.k2_rdi};
        POS_S1: byte_nxt = toh_cfg_i.s1;
        POS_Z2: byte_nxt = toh_cfg_i.z2;
        POS_E2: byte_nxt = toh_cfg_i.e2;
        default: byte_nxt = (row_r > 4'h3 && row_r < 4'h8) ? toh_cfg_i.dcc_line
                            : 8'h00;
      endcase
      if (row_r == 4'h8 && col_r == 9'h004) begin
        byte_nxt = toh_cfg_i.m0;
      end
      if (7'(row_r * 4'(TOH_COLS) + col_r) == POS_M1) begin
        byte_nxt = toh_cfg_i.m1;
      end
    end else if (col_r == 9'(TOH_COLS)) begin
      unique case (row_r)
        4'h0: byte_nxt = poh_cfg_i.j1;
        4'h1: byte_nxt = b3_r;
        4'h2: byte_nxt = poh_cfg_i.c2;
        4'h3: byte_nxt = poh_cfg_i.g1;
        4'h4: byte_nxt = poh_cfg_i.z4;
        4'h5: byte_nxt = poh_cfg_i.v5;
        4'h6: byte_nxt = poh_cfg_i.z7;
        default: byte_nxt = 8'h00;
      endcase
    end
  end

  // Registered byte output; frame_start_o is decoded from the counters
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byte_o <= '0;
    end else begin
      byte_o <= byte_nxt;
    end
  end

  assign frame_start_o = (row_r == 4'h0) && (col_r == 9'h000) && (sub_r == 2'h0);
  assign b2_reject_o   = b2_rej_r;
  assign mux_o         = mux_r;
  assign pattern_o     = pat_r;
  assign invert_o      = inv_r;

endmodule
`default_nettype wire

// ### verif/sonet_tx_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sonet_tx_checker
  import sonet_tx_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  input wire logic [1:0] rate_sel_i,
  input wire logic       b2_user_we_i,
  input wire logic       preset_i,
  input wire container_t container_i,
  input wire tcm_t       tcm_i,
  input wire pattern_t   pattern_i,
  input wire logic       invert_i,
  input wire logic [7:0] byte_o,
  input wire logic       frame_start_o,
  input wire logic       b2_reject_o,
  input wire mux_t       mux_o,
  input wire pattern_t   pattern_o,
  input wire logic       invert_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  logic [11:0] gap_r;
  logic        seen_r;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_r  <= 12'h000;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= frame_start_o ? 12'h000 : gap_r + 12'h001;
      seen_r <= seen_r | frame_start_o;
    end
  end
  sequence s_a1; (byte_o == FRAMING_1) [*3]; endsequence
  sequence s_a2; (byte_o == FRAMING_2) [*3]; endsequence
  sequence s_pat; (!preset_i && $stable(pattern_i) && $stable(invert_i)) [*2]; endsequence
  sequence s_pre; (preset_i && $stable(container_i)) [*2]; endsequence
  a_framing_bytes: assert property (
    frame_start_o && rate_sel_i == 2'h0 |=> s_a1 ##1 s_a2) else $error("framing bytes wrong");
  a_frame_period: assert property (
    seen_r && rate_sel_i == 2'h0 |-> frame_start_o == (gap_r == 12'h97D))
    else $error("frame period wrong");
  a_b2_refused: assert property (
    b2_user_we_i |=> b2_reject_o) else $error("b2 write not refused");
  a_b2_cause: assert property (
    b2_reject_o |-> $past(b2_user_we_i)) else $error("spurious b2 refusal");
  a_tcm_forces_mux: assert property (
    tcm_i != TCM_OFF |=> mux_o == mux_t'($past(tcm_i) - 2'h1)) else $error("mux not forced");
  a_tcm_off_hold: assert property (
    tcm_i == TCM_OFF |=> $stable(mux_o)) else $error("mux moved with tcm off");
  a_pattern_follow: assert property (
    s_pat |=> pattern_o == $past(pattern_i) && invert_o == $past(invert_i))
    else $error("pattern select wrong");
  a_preset_pick: assert property (
    s_pre |=> invert_o && pattern_o == (($past(container_i) inside {CONT_C4, CONT_C3_3C})
      ? PAT_PRBS23 : PAT_PRBS15)) else $error("preset pattern wrong");
endmodule
bind sonet_tx_overhead_pattern_gen sonet_tx_checker i_chk (.*);
`default_nettype wire

// ### verif/sonet_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module sonet_rx_model
  import sonet_tx_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic        frame_start_i,
  output logic [80:0][7:0] toh_o,
  output logic [7:0]       b1_seen_o,
  output logic [7:0]       b1_exp_o,
  output logic [3:0]       frames_o
);
  logic [11:0] pos_r;
  logic [7:0]  par_r;
  logic [7:0]  last_r;
  int unsigned col;
  int unsigned idx;
  assign col = pos_r % COLS;
  assign idx = (pos_r / COLS) * TOH_COLS + col;
  // Bytes before the first frame start are ignored, alignment unknown
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_r    <= 12'h000;
      frames_o <= 4'h0;
    end else begin
      pos_r <= frame_start_i ? 12'h000 : pos_r + 12'h001;
      if (frame_start_i && frames_o != 4'hF) begin
        frames_o <= frames_o + 4'h1;
      end
      if (frames_o != 4'h0) begin
        if (pos_r == 12'h000) begin
          last_r <= par_r;
          par_r  <= byte_i;
        end else begin
          par_r <= par_r ^ byte_i;
        end
        if (col < TOH_COLS) begin
          toh_o[idx] <= byte_i;
        end
        if (pos_r == 12'h10E) begin
          b1_seen_o <= byte_i;
          b1_exp_o  <= last_r;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### verif/sonet_tx_overhead_pattern_gen_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sonet_tx_overhead_pattern_gen_tb
  import sonet_tx_pkg::*;
;
  logic mclk_i = 1'b0, resetn_i = 1'b0;
  toh_cfg_t toh_cfg_i = '0;
  poh_cfg_t poh_cfg_i = '0;
  logic [1:0] rate_sel_i = 2'h0;
  logic [7:0] b2_user_i = 8'h00, idle_char_i = 8'h20, trace_char_i = 8'h00;
  logic b2_user_we_i = 1'b0, idle_char_we_i = 1'b0, trace_we_i = 1'b0;
  logic [3:0] trace_addr_i = 4'h0;
  pattern_t pattern_i = PAT_PRBS15;
  logic invert_i = 1'b0, preset_i = 1'b0, user_we_i = 1'b0;
  container_t container_i = CONT_C4;
  tcm_t tcm_i = TCM_OFF;
  logic [31:0] user_word_i = 32'h0;
  logic [5:0] user_addr_i = 6'h00;
  logic [7:0] byte_o;
  logic frame_start_o, b2_reject_o, invert_o;
  mux_t mux_o;
  pattern_t pattern_o;
  logic [80:0][7:0] toh;
  logic [7:0] b1_seen, b1_exp;
  logic [3:0] frames;
  logic [6:0] pos_v [9];
  logic [7:0] exp_v [9];
  logic [7:0] exp_pat [6];
  int num_errors = 0, n_checks = 0;
  sonet_tx_overhead_pattern_gen i_dut (.*);
  sonet_rx_model i_far (.mclk_i(mclk_i), .resetn_i(resetn_i), .byte_i(byte_o),
    .frame_start_i(frame_start_o), .toh_o(toh), .b1_seen_o(b1_seen),
    .b1_exp_o(b1_exp), .frames_o(frames));
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic step(int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic frames_wait(int n);
    repeat (n) begin
      step(1);
      while (frame_start_o !== 1'b1) step(1);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk_i);
    num_errors++;
    final_report;
  end
  initial begin
    step(2);
    resetn_i = 1'b1;
    // Side writes that have no observable byte here, driven for reach
    {trace_char_i, trace_we_i, idle_char_we_i} = {8'h41, 2'b11};
    {user_word_i, user_we_i} = {32'hF0F0_1234, 1'b1};
    step(1);
    {trace_we_i, idle_char_we_i, user_we_i} = 3'b000;
    frames_wait(1);
    for (int i = 0; i < 6; i++) begin
      step(1);
      chk("framing byte", i < 3 ? FRAMING_1 : FRAMING_2, byte_o);
    end
    $display("test framing done");
    toh_cfg_i = '{j0: 8'h4A, e1: 8'h3C, f1: 8'h5A, dcc_sec: 8'h81, k1: 8'hA5,
      k2_aps: 5'h13, k2_rdi: 3'h6, dcc_line: 8'h7E, s1: 8'h0F, z2: 8'hC3,
      m0: 8'h11, m1: 8'h96, e2: 8'h69};
    pos_v = '{POS_E1, POS_F1, POS_D1, POS_K1, POS_K2, POS_S1, POS_Z2, POS_M1, POS_E2};
    exp_v = '{8'h3C, 8'h5A, 8'h81, 8'hA5, 8'h9E, 8'h0F, 8'hC3, 8'h96, 8'h69};
    frames_wait(2);
    for (int i = 0; i < 9; i++) begin
      chk("toh byte", exp_v[i], toh[pos_v[i]]);
    end
    chk("b1 parity", b1_exp, b1_seen);
    toh_cfg_i.k1 = 8'h00;
    frames_wait(2);
    chk("b1 parity", b1_exp, b1_seen);
    $display("test overhead done");
    {b2_user_i, b2_user_we_i} = {8'hFF, 1'b1};
    step(1);
    b2_user_we_i = 1'b0;
    chk("b2 refusal", 8'h01, 8'(b2_reject_o));
    step(1);
    chk("b2 refusal end", 8'h00, 8'(b2_reject_o));
    $display("test b2 done");
    for (int t = 1; t < 4; t++) begin
      tcm_i = tcm_t'(t);
      step(3);
      chk("mux", 8'(t - 1), 8'(mux_o));
    end
    tcm_i = TCM_OFF;
    step(3);
    chk("mux kept", 8'(MUX_VT), 8'(mux_o));
    $display("test tcm done");
    preset_i = 1'b1;
    for (int c = 0; c < 5; c++) begin
      container_i = container_t'(c);
      step(3);
      chk("preset pattern", 8'(c < 2 ? PAT_PRBS23 : PAT_PRBS15), 8'(pattern_o));
      chk("preset invert", 8'h01, 8'(invert_o));
    end
    preset_i = 1'b0;
    $display("test preset done");
    exp_pat = '{8'h00, 8'hFF, 8'h55, 8'h88, 8'h80, 8'h42};
    for (int p = 0; p < 28; p++) begin
      pattern_i = pattern_t'(p / 2);
      invert_i = 1'(p);
      step(3);
      chk("pattern", 8'(p / 2), 8'(pattern_o));
      chk("invert", 8'(p % 2), 8'(invert_o));
      if (p >= 16) begin
        frames_wait(1);
        step(20);
        chk("payload", exp_pat[p / 2 - 8] ^ {8{invert_i}}, byte_o);
      end
    end
    $display("test patterns done");
    final_report;
  end
endmodule
`default_nettype wire
